// ### core/bcdclk_top.sv
// packed bcd clock and calendar with an axi4-lite register slave
`timescale 1ns/1ps
`include "bcdclk_defines.svh"
module bcdclk_top
    import bcdclk_pkg::*;
#(parameter int unsigned TICK_CYCLES = `BCDCLK_TICK_CYCLES) // cycles a second
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // bcd increment of one byte, wrapping to a given floor past a ceiling
    function automatic logic [7:0] bcdInc(input logic [7:0] v,
                                          input logic [7:0] top,
                                          input logic [7:0] floor);
        if (v >= top) begin
            bcdInc = floor;
        end else if (v[3:0] >= 4'h9) begin
            bcdInc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcdInc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // last day of the month; years 00..99 stand for 2000..2099
    function automatic logic [7:0] monthEnd(input logic [7:0] mon,
                                            input logic [7:0] yr);
        logic leap;
        leap = (yr[4] ? (yr[1:0] == 2'b10) : (yr[1:0] == 2'b00));
        case (mon)
            `BCDCLK_FEB: monthEnd = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: monthEnd = 8'h30;
            default: monthEnd = 8'h31;
        endcase
    endfunction

    bcdclk_time_t now, next_now, stage, next_stage;
    logic [23:0] tick, next_tick;
    logic loadPulse;
    // write channel state
    bcdclk_wstate_t wState, next_wState;
    logic awTaken, next_awTaken, wTaken, next_wTaken;
    logic [5:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrb, next_wStrb;
    logic [1:0] bResp, next_bResp;
    logic awReady, next_awReady, wReady, next_wReady, bValid, next_bValid;
    // read channel state
    logic arReady, next_arReady, rValid, next_rValid;
    logic [31:0] rData, next_rData;
    logic [1:0] rResp, next_rResp;

    // merge a 16-bit word with the byte strobes
    function automatic logic [15:0] mergeWord(input logic [15:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] s);
        mergeWord = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // write handshake: address and data taken independently, reply after both
    always_comb begin
        logic [15:0] w;
        w = 16'h0000;
        next_wState = wState;
        next_awTaken = awTaken;
        next_wTaken = wTaken;
        next_awAddr = awAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bResp = bResp;
        next_bValid = bValid;
        next_awReady = awReady;
        next_wReady = wReady;
        next_stage = stage;
        loadPulse = 1'b0;
        case (wState)
            BCDCLK_W_IDLE: begin
                if (s_axi_awvalid && awReady) begin
                    next_awTaken = 1'b1;
                    next_awAddr = s_axi_awaddr;
                    next_awReady = 1'b0;
                end
                if (s_axi_wvalid && wReady) begin
                    next_wTaken = 1'b1;
                    next_wData = s_axi_wdata;
                    next_wStrb = s_axi_wstrb;
                    next_wReady = 1'b0;
                end
                if (awTaken && wTaken) begin
                    next_bResp = `BCDCLK_RESP_OKAY;
                    case (awAddr)
                        `BCDCLK_OFF_MS: begin
                            w = mergeWord({stage.minute, stage.second},
                                          wData, wStrb);
                            next_stage.minute = w[15:8];
                            next_stage.second = w[7:0];
                        end
                        `BCDCLK_OFF_DH: begin
                            w = mergeWord({stage.day, stage.hour},
                                          wData, wStrb);
                            next_stage.day = w[15:8];
                            next_stage.hour = w[7:0];
                        end
                        `BCDCLK_OFF_YM: begin
                            w = mergeWord({stage.year, stage.month},
                                          wData, wStrb);
                            next_stage.year = w[15:8];
                            next_stage.month = w[7:0];
                        end
                        `BCDCLK_OFF_WD: begin
                            w = mergeWord({8'h00, stage.weekday},
                                          wData, wStrb);
                            next_stage.weekday = w[7:0];
                        end
                        `BCDCLK_OFF_TRIG: begin
                            // edge-free: one load per write, not per cycle held
                            w = mergeWord(16'h0000, wData, wStrb);
                            loadPulse = (w == `BCDCLK_LOAD_CODE);
                        end
                        `BCDCLK_OFF_HM: begin
                            next_bResp = `BCDCLK_RESP_SLVERR; // read only
                        end
                        default: begin
                            next_bResp = `BCDCLK_RESP_SLVERR;
                        end
                    endcase
                    next_awTaken = 1'b0;
                    next_wTaken = 1'b0;
                    next_bValid = 1'b1;
                    next_wState = BCDCLK_W_RESP;
                end
            end
            BCDCLK_W_RESP: begin
                if (s_axi_bready) begin
                    next_bValid = 1'b0;
                    next_awReady = 1'b1;
                    next_wReady = 1'b1;
                    next_wState = BCDCLK_W_IDLE;
                end
            end
            default: begin
                next_wState = BCDCLK_W_IDLE;
            end
        endcase
    end

    // time base and calendar carry chain; a load wins over a tick
    always_comb begin
        logic [7:0] last;
        next_now = now;
        next_tick = tick;
        last = monthEnd(now.month, now.year);
        if (loadPulse) begin
            next_now = stage;
            next_tick = 24'h000000;
        end else if (tick >= 24'(TICK_CYCLES - 1)) begin
            next_tick = 24'h000000;
            next_now.second = bcdInc(now.second, `BCDCLK_SEC_MAX,
                                     `BCDCLK_ZERO);
            if (now.second >= `BCDCLK_SEC_MAX) begin
                next_now.minute = bcdInc(now.minute, `BCDCLK_MIN_MAX,
                                         `BCDCLK_ZERO);
                if (now.minute >= `BCDCLK_MIN_MAX) begin
                    next_now.hour = bcdInc(now.hour, `BCDCLK_HOUR_MAX,
                                           `BCDCLK_ZERO);
                    if (now.hour >= `BCDCLK_HOUR_MAX) begin
                        next_now.weekday = bcdInc(now.weekday,
                                                  `BCDCLK_WDAY_MAX,
                                                  `BCDCLK_ZERO);
                        next_now.day = bcdInc(now.day, last,
                                              `BCDCLK_ONE);
                        if (now.day >= last) begin
                            next_now.month = bcdInc(now.month,
                                                    `BCDCLK_MON_MAX,
                                                    `BCDCLK_ONE);
                            if (now.month >= `BCDCLK_MON_MAX) begin
                                next_now.year = bcdInc(now.year,
                                                       `BCDCLK_YEAR_MAX,
                                                       `BCDCLK_ZERO);
                            end
                        end
                    end
                end
            end
        end else begin
            next_tick = tick + 24'h000001;
        end
    end

    // read channel: one read at a time, data one cycle after the address
    always_comb begin
        next_arReady = arReady;
        next_rValid = rValid;
        next_rData = rData;
        next_rResp = rResp;
        if (s_axi_arvalid && arReady) begin
            next_arReady = 1'b0;
            next_rValid = 1'b1;
            next_rResp = `BCDCLK_RESP_OKAY;
            case (s_axi_araddr)
                `BCDCLK_OFF_HM: next_rData = {16'h0000, now.hour,
                                             now.minute};
                `BCDCLK_OFF_MS: next_rData = {16'h0000, now.minute,
                                             now.second};
                `BCDCLK_OFF_DH: next_rData = {16'h0000, now.day,
                                             now.hour};
                `BCDCLK_OFF_YM: next_rData = {16'h0000, now.year,
                                             now.month};
                `BCDCLK_OFF_WD: next_rData = {24'h000000, now.weekday};
                `BCDCLK_OFF_TRIG: next_rData = 32'h00000000;
                default: begin
                    next_rData = 32'h00000000;
                    next_rResp = `BCDCLK_RESP_SLVERR;
                end
            endcase
        end else if (rValid && s_axi_rready) begin
            next_rValid = 1'b0;
            next_arReady = 1'b1;
        end
    end

    // registers; calendar resets to 2000-01-01 00:00:00, weekday code 0
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            now <= '{`BCDCLK_RST_YEAR, `BCDCLK_RST_MON, `BCDCLK_RST_DAY,
                     8'h00, 8'h00, 8'h00, 8'h00};
            stage <= '{`BCDCLK_RST_YEAR, `BCDCLK_RST_MON, `BCDCLK_RST_DAY,
                       8'h00, 8'h00, 8'h00, 8'h00};
            tick <= 24'h000000;
            wState <= BCDCLK_W_IDLE;
            awTaken <= 1'b0;
            wTaken <= 1'b0;
            awAddr <= 6'h00;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
            bResp <= 2'b00;
            bValid <= 1'b0;
            awReady <= 1'b1;
            wReady <= 1'b1;
            arReady <= 1'b1;
            rValid <= 1'b0;
            rData <= 32'h00000000;
            rResp <= 2'b00;
        end else begin
            now <= next_now;
            stage <= next_stage;
            tick <= next_tick;
            wState <= next_wState;
            awTaken <= next_awTaken;
            wTaken <= next_wTaken;
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            bResp <= next_bResp;
            bValid <= next_bValid;
            awReady <= next_awReady;
            wReady <= next_wReady;
            arReady <= next_arReady;
            rValid <= next_rValid;
            rData <= next_rData;
            rResp <= next_rResp;
        end
    end

    assign s_axi_awready = awReady;
    assign s_axi_wready = wReady;
    assign s_axi_bvalid = bValid;
    assign s_axi_bresp = bResp;
    assign s_axi_arready = arReady;
    assign s_axi_rvalid = rValid;
    assign s_axi_rdata = rData;
    assign s_axi_rresp = rResp;
endmodule

// ### core/bcdclk_defines.svh
// register offsets, field limits, reset values and timing counts
`ifndef BCDCLK_DEFINES_SVH
`define BCDCLK_DEFINES_SVH
`define BCDCLK_OFF_HM      6'h00
`define BCDCLK_OFF_MS      6'h04
`define BCDCLK_OFF_DH      6'h08
`define BCDCLK_OFF_YM      6'h0c
`define BCDCLK_OFF_WD      6'h10
`define BCDCLK_OFF_TRIG    6'h14
`define BCDCLK_LOAD_CODE   16'h8000
`define BCDCLK_CLK_HZ      10000000
`define BCDCLK_TICK_PERIOD_S 1
`define BCDCLK_TICK_CYCLES (`BCDCLK_CLK_HZ * `BCDCLK_TICK_PERIOD_S)
`define BCDCLK_TICK_LAST   24'(`BCDCLK_TICK_CYCLES - 1)
`define BCDCLK_SEC_MAX     8'h59
`define BCDCLK_MIN_MAX     8'h59
`define BCDCLK_HOUR_MAX    8'h23
`define BCDCLK_MON_MAX     8'h12
`define BCDCLK_YEAR_MAX    8'h99
`define BCDCLK_WDAY_MAX    8'h06
`define BCDCLK_FEB         8'h02
`define BCDCLK_ZERO        8'h00
`define BCDCLK_ONE         8'h01
`define BCDCLK_RST_YEAR    8'h00
`define BCDCLK_RST_MON     8'h01
`define BCDCLK_RST_DAY     8'h01
`define BCDCLK_RESP_OKAY   2'b00
`define BCDCLK_RESP_SLVERR 2'b10
`endif

// ### core/bcdclk_pkg.sv
// types shared by the clock and calendar block
package bcdclk_pkg;
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
        logic [7:0] weekday;
    } bcdclk_time_t;

    typedef enum logic [1:0] {BCDCLK_W_IDLE, BCDCLK_W_RESP} bcdclk_wstate_t;
endpackage

// ### verif/bcdclk_assertions.sv
// concurrent checks on the bcd clock and calendar register slave
`timescale 1ns/1ps
`include "bcdclk_defines.svh"
module bcdclk_assertions (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // write taken in one edge is answered two edges later
    AST_B_LATENCY: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two edges after take");
    AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one edge after take");
    // arready stays low until the read handshake frees it
    AST_AR_BLOCK: assert property (!s_axi_arready &&
        !(s_axi_rvalid && s_axi_rready) |=> !s_axi_arready)
        else $error("read address accepted while busy");
    AST_AW_BLOCK: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    AST_RDATA_UPPER: assert property (s_axi_rvalid |->
        s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    AST_RO_WRITE: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready && s_axi_awaddr == 6'h00
        |=> ##1 s_axi_bvalid && s_axi_bresp == 2'b10)
        else $error("write to readback word not refused");
    AST_UNMAPPED_RD: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr > 6'h14 |=> s_axi_rresp == 2'b10
        && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_HM_RANGE: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 6'h00 |=> s_axi_rdata[15:8] <= 8'h23
        && s_axi_rdata[7:0] <= 8'h59 && s_axi_rresp == 2'b00)
        else $error("hour minute word out of range");
    AST_WD_RANGE: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 6'h10 |=> s_axi_rdata[15:0] <= 16'h0006)
        else $error("weekday out of range");
    AST_TRIG_ZERO: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 6'h14 |=> s_axi_rdata == 32'h0)
        else $error("trigger word reads nonzero");
    AST_RESET_IDLE: assert property ($fell(reset) |-> s_axi_awready
        && s_axi_wready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus not idle after reset");
endmodule
bind bcdclk_top bcdclk_assertions i_bcdclk_assertions (.ref_clk, .reset,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ### verif/bcdclk_top_bench.sv
// self-checking bench for the bcd clock and calendar block
`timescale 1ns/1ps
`include "bcdclk_defines.svh"
module bcdclk_top_bench;
    // a real second is far too long to simulate; the bench second is 20 cycles
    localparam int TICK = 20;
    localparam logic [1:0] OK = `BCDCLK_RESP_OKAY;
    localparam logic [1:0] ER = `BCDCLK_RESP_SLVERR;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [33:0] expQ[$];
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    // staged {year, month, day, weekday} at 23:59:59 and one second later
    logic [31:0] stg[5] = '{32'h99123106, 32'h24022802, 32'h23022800,
        32'h00022905, 32'h21043003};
    logic [31:0] nxt[5] = '{32'h00010100, 32'h24022903, 32'h23030101,
        32'h00030106, 32'h21050104};

    always #50 ref_clk = ~ref_clk;

    bcdclk_top #(.TICK_CYCLES(TICK)) i_bcdclk_top (.ref_clk, .reset,
        .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    function automatic logic [7:0] bcd(input int v);
        return {4'(v / 10), 4'(v % 10)};
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic compare(input logic [33:0] got);
        logic [33:0] exp;
        exp = expQ.pop_front();
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // write both channels together; extra edge keeps drives one per step
    task automatic wr(input logic [5:0] a, input logic [15:0] d,
                      input logic [1:0] r);
        expQ.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] d,
                      input logic [1:0] r);
        expQ.push_back({r, 16'h0, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    // response watcher: the oldest note goes with each handshake
    always @(posedge ref_clk) begin
        if (s_axi_bvalid && s_axi_bready) compare({s_axi_bresp, 32'h0});
        if (s_axi_rvalid && s_axi_rready) compare({s_axi_rresp, s_axi_rdata});
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        int mi, se, hr;
        void'($urandom(32'h897c6ac2));
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(`BCDCLK_OFF_HM, 16'h0000, OK);
        rd(`BCDCLK_OFF_DH, 16'h0100, OK);
        rd(`BCDCLK_OFF_YM, 16'h0001, OK);
        rd(`BCDCLK_OFF_WD, 16'h0000, OK);
        rd(`BCDCLK_OFF_TRIG, 16'h0000, OK);
        $display("reset values done");
        rd(6'h18, 16'h0000, ER);
        wr(`BCDCLK_OFF_HM, 16'h1234, ER);
        wr(6'h1c, 16'h1234, ER);
        rd(`BCDCLK_OFF_HM, 16'h0000, OK);
        $display("refused access done");
        foreach (stg[i]) begin
            wr(`BCDCLK_OFF_MS, 16'h5959, OK);
            wr(`BCDCLK_OFF_DH, {stg[i][15:8], 8'h23}, OK);
            wr(`BCDCLK_OFF_YM, stg[i][31:16], OK);
            wr(`BCDCLK_OFF_WD, {8'h0, stg[i][7:0]}, OK);
            wr(`BCDCLK_OFF_TRIG, `BCDCLK_LOAD_CODE, OK);
            repeat (TICK + 1) @(posedge ref_clk);
            rd(`BCDCLK_OFF_MS, 16'h0000, OK);
            rd(`BCDCLK_OFF_HM, 16'h0000, OK);
            rd(`BCDCLK_OFF_DH, {nxt[i][15:8], 8'h00}, OK);
            rd(`BCDCLK_OFF_YM, nxt[i][31:16], OK);
            rd(`BCDCLK_OFF_WD, {8'h0, nxt[i][7:0]}, OK);
            $display("rollover case %0d done", i);
        end
        wr(`BCDCLK_OFF_YM, 16'h5505, OK);
        wr(`BCDCLK_OFF_TRIG, 16'h0000, OK);
        rd(`BCDCLK_OFF_YM, 16'h2105, OK);
        $display("zero trigger done");
        repeat (4) begin
            mi = $urandom % 60;
            se = $urandom % 60;
            hr = $urandom % 24;
            wr(`BCDCLK_OFF_MS, {bcd(mi), bcd(se)}, OK);
            wr(`BCDCLK_OFF_DH, {8'h01, bcd(hr)}, OK);
            wr(`BCDCLK_OFF_TRIG, `BCDCLK_LOAD_CODE, OK);
            rd(`BCDCLK_OFF_MS, {bcd(mi), bcd(se)}, OK);
            rd(`BCDCLK_OFF_HM, {bcd(hr), bcd(mi)}, OK);
        end
        $display("random loads done");
        report_and_stop();
    end
endmodule
